// file: ldc_cfg.svh
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH
// ==========================================
// Clock and time base
`define LDC_CLK_KHZ 100000
`define LDC_MS2CYC(ms) (40'(ms) * 40'(`LDC_CLK_KHZ))
`define LDC_TUNE_MS 5000
`define LDC_HOLD_1S_MS 1000
`define LDC_HOLD_4M_MS 240000
`define LDC_HOLD_40M_MS 2400000
`define LDC_PARALYSIS_MS 4000
`define LDC_PULSE_MS 150
`define LDC_DRIFT_MS 60000
`define LDC_DEBOUNCE_MS 20
// ==========================================
// Relative inductance change, parts per 100000
`define LDC_SENS_HI 16'd20
`define LDC_SENS_MHI 16'd50
`define LDC_SENS_MLO 16'd100
`define LDC_SENS_LO 16'd500
`define LDC_RETUNE_PPK 16'd15000
`define LDC_DRIFT_PPK 16'd1000
`define LDC_NOTO_DRIFT_PPK 16'd50
// ==========================================
// Register map
`define LDC_REG_CTRL 8'h00
`define LDC_REG_STATUS 8'h04
`define LDC_REG_IRQ_STAT 8'h08
`define LDC_REG_IRQ_MASK 8'h0C
`define LDC_REG_BASE0 8'h10
`define LDC_REG_BASE1 8'h14
`define LDC_CTRL_RETUNE 0
`define LDC_IRQ_DET0 0
`define LDC_IRQ_DET1 1
`define LDC_IRQ_FLT0 2
`define LDC_IRQ_FLT1 3
`define LDC_IRQ_TUNED 4
`define LDC_IRQ_BIG 5
`define LDC_IRQ_MASK_RST 6'h00
`define LDC_RESP_OK 2'h0
`define LDC_RESP_ERR 2'h2
`endif

// file: ldc_pkg.sv
package ldc_pkg;
	typedef enum logic [1:0] {FREQ_HIGH, FREQ_MHIGH, FREQ_MLOW, FREQ_LOW} ldc_freq_type;
	typedef enum logic [1:0] {SENS_HIGH, SENS_MHIGH, SENS_MLOW, SENS_LOW} ldc_sens_type;
	typedef enum logic [1:0] {HOLD_NONE, HOLD_40M, HOLD_4M, HOLD_1S} ldc_hold_type;
	typedef enum logic [1:0] {CH_IDLE, CH_DETECT, CH_PARALYSED} ldc_chst_type;
	typedef struct packed {
		logic ch1OutputModeSel;
		logic ch2OutputModeSel;
		logic holdTimeBitA;
		logic holdTimeBitB;
		logic ch1SensBitA;
		logic ch1SensBitB;
		logic ch2SensBitA;
		logic ch2SensBitB;
		logic freqSelectHiBit;
		logic freqSelectLoBit;
	} ldc_sw_type;
	typedef struct packed {
		ldc_freq_type freq;
		ldc_sens_type [1:0] sens;
		ldc_hold_type hold;
		logic [1:0] pulseMode;
	} ldc_cfg_type;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} ldc_axi_req_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ldc_axi_rsp_type;
	typedef struct packed {
		ldc_chst_type st;
		logic [23:0] base;
		logic [23:0] lastCnt;
		logic [39:0] tmr;
		logic [23:0] pulseTmr;
		logic fltPrev;
		logic fltHist;
		logic relay;
		logic led;
	} ldc_chan_type;
	typedef struct packed {
		ldc_chan_type [1:0] ch;
		ldc_sw_type swS1;
		ldc_sw_type swS2;
		ldc_sw_type swS3;
		ldc_sw_type swStable;
		logic btnS1;
		logic btnS2;
		logic btnS3;
		logic btnStable;
		logic [23:0] debCnt;
		logic booted;
		logic tuning;
		logic [39:0] tuneTmr;
		logic [39:0] driftTmr;
		logic [25:0] blink;
		ldc_cfg_type cfg;
		logic loopSel;
		logic powerLed;
		logic irq;
		logic [5:0] irqStat;
		logic [5:0] irqMask;
		logic awHave;
		logic wHave;
		logic [7:0] awAddr;
		logic [7:0] wData;
		logic wStrb0;
		ldc_axi_rsp_type rsp;
	} ldc_state_type;
endpackage

// file: ldc_channel_control.sv
`timescale 1ns/1ps
`include "ldc_cfg.svh"
module ldc_channel_control #(
	parameter logic [39:0] TUNE_CYC = `LDC_MS2CYC(`LDC_TUNE_MS),
	parameter logic [39:0] HOLD_1S_CYC = `LDC_MS2CYC(`LDC_HOLD_1S_MS),
	parameter logic [39:0] HOLD_4M_CYC = `LDC_MS2CYC(`LDC_HOLD_4M_MS),
	parameter logic [39:0] HOLD_40M_CYC = `LDC_MS2CYC(`LDC_HOLD_40M_MS),
	parameter logic [39:0] PARALYSIS_CYC = `LDC_MS2CYC(`LDC_PARALYSIS_MS),
	parameter logic [39:0] DRIFT_CYC = `LDC_MS2CYC(`LDC_DRIFT_MS),
	parameter logic [23:0] PULSE_CYC = 24'(`LDC_MS2CYC(`LDC_PULSE_MS)),
	parameter logic [23:0] DEBOUNCE_CYC = 24'(`LDC_MS2CYC(`LDC_DEBOUNCE_MS))
) (
	input wire logic clk,
	input wire logic srst,
	input wire ldc_pkg::ldc_sw_type swPins,
	input wire logic resetButton_n,
	input wire logic measValid,
	input wire logic [23:0] measCount,
	input wire logic [1:0] loopFault,
	input wire ldc_pkg::ldc_axi_req_type axiReq,
	output ldc_pkg::ldc_axi_rsp_type axiRsp,
	output logic loopSel,
	output ldc_pkg::ldc_freq_type freqSel,
	output logic [1:0] relayCoil,
	output logic [1:0] chLed,
	output logic powerLed,
	output logic irq
);
	import ldc_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic [23:0] relThr(input logic [23:0] b, input logic [15:0] ppk);
		logic [39:0] p;
		// Oscillator frequency moves by about half the relative inductance change
		p = ({16'h0000, b} * {24'h000000, ppk}) / 40'h0000030D40;
		relThr = (p[23:0] == 24'h000000) ? 24'h000001 : p[23:0];
	endfunction

	// A limit counts cycles, so a timer started at zero is on its last cycle at limit minus one
	function automatic logic lastCyc(input logic [39:0] t, input logic [39:0] lim);
		lastCyc = t == lim - 40'h0000000001;
	endfunction

	function automatic logic [31:0] statusWord(input ldc_state_type s);
		statusWord = {17'h00000, s.cfg, s.ch[1].fltHist, s.ch[0].fltHist,
			s.ch[1].st == CH_DETECT, s.ch[0].st == CH_DETECT, s.tuning};
	endfunction

	function automatic logic [15:0] sensPpk(input ldc_sens_type s);
		case (s)
			SENS_HIGH: sensPpk = `LDC_SENS_HI;
			SENS_MHIGH: sensPpk = `LDC_SENS_MHI;
			SENS_MLOW: sensPpk = `LDC_SENS_MLO;
			default: sensPpk = `LDC_SENS_LO;
		endcase
	endfunction

	function automatic logic [39:0] holdCyc(input ldc_hold_type h);
		case (h)
			HOLD_1S: holdCyc = HOLD_1S_CYC;
			HOLD_4M: holdCyc = HOLD_4M_CYC;
			HOLD_40M: holdCyc = HOLD_40M_CYC;
			default: holdCyc = 40'h0000000000;
		endcase
	endfunction

	function automatic ldc_cfg_type cfgOf(input ldc_sw_type s);
		ldc_cfg_type c;
		c.freq = ldc_freq_type'({s.freqSelectHiBit, s.freqSelectLoBit});
		c.sens[0] = ldc_sens_type'({s.ch1SensBitB, s.ch1SensBitA});
		c.sens[1] = ldc_sens_type'({s.ch2SensBitB, s.ch2SensBitA});
		c.hold = ldc_hold_type'({s.holdTimeBitB, s.holdTimeBitA});
		c.pulseMode = {s.ch2OutputModeSel, s.ch1OutputModeSel};
		cfgOf = c;
	endfunction

	ldc_state_type r;
	ldc_state_type n;

	// ==========================================
	// Next state
	always_comb begin
		logic startTune;
		logic hit;
		logic big;
		logic mine;
		logic [23:0] dlt;
		logic [23:0] step;
		logic [5:0] evt;
		logic [5:0] clr;
		logic [31:0] rd;
		startTune = 1'b0;
		hit = 1'b0;
		big = 1'b0;
		mine = 1'b0;
		dlt = 24'h000000;
		step = 24'h000000;
		evt = 6'h00;
		clr = 6'h00;
		rd = 32'h00000000;
		n = r;
		n.powerLed = 1'b1;
		n.blink = r.blink + 26'h0000001;

		// Pins from outside: three stages, a bit changes once stages two and three agree
		n.swS1 = swPins;
		n.swS2 = r.swS1;
		n.swS3 = r.swS2;
		n.swStable = (r.swS2 & r.swS3) | (r.swStable & (r.swS2 ^ r.swS3));
		n.btnS1 = resetButton_n;
		n.btnS2 = r.btnS1;
		n.btnS3 = r.btnS2;
		n.debCnt = 24'h000000;
		// Press and release each need DEBOUNCE_CYC quiet cycles; only a settled press starts tuning
		if (r.btnS2 == r.btnS3 && r.btnS3 != r.btnStable) begin
			n.debCnt = r.debCnt + 24'h000001;
			if (r.debCnt == DEBOUNCE_CYC - 24'h000001) begin
				n.btnStable = r.btnS3;
				n.debCnt = 24'h000000;
				if (!r.btnS3) begin
					startTune = 1'b1;
				end
			end
		end

		// Wait a few cycles after reset so the switch stages hold real levels
		if (!r.booted && r.blink[3]) begin
			n.booted = 1'b1;
			startTune = 1'b1;
		end

		// ==========================================
		// Register bus
		if (r.rsp.bvalid && axiReq.bready) begin
			n.rsp.bvalid = 1'b0;
		end
		// Address and data may come in either order; the write acts once both are held
		if (r.rsp.awready && axiReq.awvalid) begin
			n.awHave = 1'b1;
			n.awAddr = axiReq.awaddr;
		end
		if (r.rsp.wready && axiReq.wvalid) begin
			n.wHave = 1'b1;
			n.wData = axiReq.wdata[7:0];
			n.wStrb0 = axiReq.wstrb[0];
		end
		if (r.awHave && r.wHave && !r.rsp.bvalid) begin
			n.awHave = 1'b0;
			n.wHave = 1'b0;
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = `LDC_RESP_OK;
			case (r.awAddr)
				`LDC_REG_CTRL: begin
					if (r.wStrb0 && r.wData[`LDC_CTRL_RETUNE]) begin
						startTune = 1'b1;
					end
				end
				`LDC_REG_STATUS: begin
				end
				`LDC_REG_IRQ_STAT: begin
					if (r.wStrb0) begin
						clr = r.wData[5:0];
					end
				end
				`LDC_REG_IRQ_MASK: begin
					if (r.wStrb0) begin
						n.irqMask = r.wData[5:0];
					end
				end
				`LDC_REG_BASE0: begin
				end
				`LDC_REG_BASE1: begin
				end
				default: n.rsp.bresp = `LDC_RESP_ERR;
			endcase
		end
		if (r.rsp.rvalid && axiReq.rready) begin
			n.rsp.rvalid = 1'b0;
		end
		// Read data come from this cycle's registers and stand until taken
		if (r.rsp.arready && axiReq.arvalid) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rresp = `LDC_RESP_OK;
			case (axiReq.araddr)
				`LDC_REG_CTRL: rd = 32'h00000000;
				`LDC_REG_STATUS: rd = statusWord(r);
				`LDC_REG_IRQ_STAT: rd = {26'h0000000, r.irqStat};
				`LDC_REG_IRQ_MASK: rd = {26'h0000000, r.irqMask};
				`LDC_REG_BASE0: rd = {8'h00, r.ch[0].base};
				`LDC_REG_BASE1: rd = {8'h00, r.ch[1].base};
				default: n.rsp.rresp = `LDC_RESP_ERR;
			endcase
			n.rsp.rdata = rd;
		end

		// ==========================================
		// Measurement multiplexer and drift tick
		// The gate after a valid count belongs to the other loop
		if (measValid) begin
			n.loopSel = ~r.loopSel;
		end
		n.driftTmr = r.driftTmr + 40'h0000000001;
		if (lastCyc(r.driftTmr, DRIFT_CYC)) begin
			n.driftTmr = 40'h0000000000;
		end

		// ==========================================
		// Channels
		for (int c = 0; c < 2; c++) begin
			mine = measValid && (r.loopSel == c[0]);
			if (mine) begin
				n.ch[c].lastCnt = measCount;
			end
			dlt = (measCount > r.ch[c].base) ? measCount - r.ch[c].base : 24'h000000;
			hit = dlt >= relThr(r.ch[c].base, sensPpk(r.cfg.sens[c]));
			big = dlt >= relThr(r.ch[c].base, `LDC_RETUNE_PPK);
			if (r.ch[c].pulseTmr != 24'h000000) begin
				n.ch[c].pulseTmr = r.ch[c].pulseTmr - 24'h000001;
			end
			n.ch[c].fltPrev = loopFault[c];
			if (loopFault[c]) begin
				n.ch[c].fltHist = 1'b1;
			end
			if (loopFault[c] && !r.ch[c].fltPrev) begin
				evt[`LDC_IRQ_FLT0 + c] = 1'b1;
			end
			// While tuning a measurement only loads the baseline
			if (r.tuning) begin
				if (mine) begin
					n.ch[c].base = measCount;
				end
			end else begin
				// Loop inductance above reference cannot be a vehicle: follow at once
				if (mine && measCount < r.ch[c].base && r.ch[c].st != CH_DETECT) begin
					n.ch[c].base = measCount;
				end
				// Slow upward drift, much slower while holding presence without timeout
				if (lastCyc(r.driftTmr, DRIFT_CYC) && r.ch[c].lastCnt > r.ch[c].base) begin
					if (r.ch[c].st != CH_DETECT) begin
						step = relThr(r.ch[c].base, `LDC_DRIFT_PPK);
					end else if (r.cfg.hold == HOLD_NONE) begin
						step = relThr(r.ch[c].base, `LDC_NOTO_DRIFT_PPK);
					end else begin
						step = 24'h000000;
					end
					if (r.ch[c].lastCnt - r.ch[c].base < step) begin
						step = r.ch[c].lastCnt - r.ch[c].base;
					end
					n.ch[c].base = r.ch[c].base + step;
				end
				case (r.ch[c].st)
					CH_IDLE: begin
						n.ch[c].tmr = 40'h0000000000;
						if (mine && hit) begin
							n.ch[c].st = CH_DETECT;
							evt[`LDC_IRQ_DET0 + c] = 1'b1;
							if (r.cfg.pulseMode[c]) begin
								n.ch[c].pulseTmr = PULSE_CYC;
							end
						end
					end
					CH_DETECT: begin
						n.ch[c].tmr = r.ch[c].tmr + 40'h0000000001;
						if (mine && !hit) begin
							n.ch[c].tmr = 40'h0000000000;
							n.ch[c].st = (r.cfg.hold == HOLD_1S) ? CH_IDLE : CH_PARALYSED;
						end else if (r.cfg.hold != HOLD_NONE &&
							lastCyc(r.ch[c].tmr, holdCyc(r.cfg.hold))) begin
							// Tune out the vehicle at expiry
							n.ch[c].base = r.ch[c].lastCnt;
							n.ch[c].tmr = 40'h0000000000;
							n.ch[c].st = (r.cfg.hold == HOLD_1S) ? CH_IDLE : CH_PARALYSED;
						end
					end
					CH_PARALYSED: begin
						n.ch[c].tmr = r.ch[c].tmr + 40'h0000000001;
						// Hits are ignored until the blocking interval has run out
						if (lastCyc(r.ch[c].tmr, PARALYSIS_CYC)) begin
							n.ch[c].tmr = 40'h0000000000;
							n.ch[c].st = CH_IDLE;
						end
					end
					default: n.ch[c].st = CH_IDLE;
				endcase
				if (mine && big) begin
					evt[`LDC_IRQ_BIG] = 1'b1;
					startTune = 1'b1;
				end
			end
		end

		// ==========================================
		// Tuning
		if (r.tuning) begin
			n.tuneTmr = r.tuneTmr + 40'h0000000001;
			if (lastCyc(r.tuneTmr, TUNE_CYC)) begin
				n.tuning = 1'b0;
				evt[`LDC_IRQ_TUNED] = 1'b1;
			end
		end
		if (startTune) begin
			n.tuning = 1'b1;
			n.tuneTmr = 40'h0000000000;
			n.cfg = cfgOf(r.swStable);
			// Any start clears channel states; fault history reloads from the pins
			for (int c = 0; c < 2; c++) begin
				n.ch[c].st = CH_IDLE;
				n.ch[c].tmr = 40'h0000000000;
				n.ch[c].pulseTmr = 24'h000000;
				n.ch[c].fltHist = loopFault[c];
			end
		end

		// ==========================================
		// Outputs
		for (int c = 0; c < 2; c++) begin
			if (n.cfg.pulseMode[c]) begin
				n.ch[c].relay = n.ch[c].pulseTmr != 24'h000000;
			end else begin
				// Coil held while quiet, so a dead supply also closes the contact
				n.ch[c].relay = !(n.ch[c].st == CH_DETECT || loopFault[c]);
			end
			if (n.tuning || n.ch[c].st == CH_DETECT) begin
				n.ch[c].led = 1'b1;
			end else begin
				n.ch[c].led = n.ch[c].fltHist & r.blink[25];
			end
		end
		// Hardware set wins over a simultaneous software clear
		n.irqStat = (r.irqStat & ~clr) | evt;
		n.irq = |(n.irqStat & n.irqMask);
		// Ready stays low while a request is held, so a second one waits
		n.rsp.awready = !n.awHave;
		n.rsp.wready = !n.wHave;
		n.rsp.arready = !n.rsp.rvalid;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			r.irqMask <= `LDC_IRQ_MASK_RST;
		end else begin
			r <= n;
		end
	end

	assign axiRsp = r.rsp;
	assign loopSel = r.loopSel;
	assign freqSel = r.cfg.freq;
	assign relayCoil = {r.ch[1].relay, r.ch[0].relay};
	assign chLed = {r.ch[1].led, r.ch[0].led};
	assign powerLed = r.powerLed;
	assign irq = r.irq;
endmodule

// file: ldc_channel_control_assertions.sv
`timescale 1ns/1ps
module ldc_channel_control_assertions (
	input wire logic clk,
	input wire logic srst,
	input wire logic measValid,
	input wire ldc_pkg::ldc_axi_req_type axiReq,
	input wire ldc_pkg::ldc_axi_rsp_type axiRsp,
	input wire logic loopSel,
	input wire ldc_pkg::ldc_freq_type freqSel,
	input wire logic [1:0] relayCoil,
	input wire logic [1:0] chLed,
	input wire logic powerLed,
	input wire logic irq
);
	import ldc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ====================
	// Outputs
	a_power_lamp: assert property ((!srst) [*3] |-> powerLed) else $error("power lamp dark");
	a_reset_safe: assert property ($fell(srst) |-> relayCoil == 2'h0 && !irq) else $error("unsafe after reset");
	a_loop_swap: assert property (measValid |=> loopSel != $past(loopSel)) else $error("loop not swapped");
	// Settings may only move when a tuning cycle starts, which lights both lamps
	a_cfg_held: assert property ($changed(freqSel) && !$past(srst) |-> ##[0:2] chLed == 2'h3)
		else $error("setting moved outside tuning");
	// ====================
	// Register bus
	a_write_resp: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
		|-> ##[1:2] axiRsp.bvalid) else $error("no write answer");
	a_read_resp: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid) else $error("no read answer");
	a_read_block: assert property (axiRsp.rvalid |-> !axiRsp.arready) else $error("read taken while busy");
	a_addr_block: assert property (axiReq.awvalid && axiRsp.awready |=> !axiRsp.awready) else $error("address twice");
	c_detect: cover property (measValid ##1 relayCoil == 2'h2);
	c_irq: cover property ($rose(irq));
	c_tune: cover property (chLed == 2'h3);
endmodule
bind ldc_channel_control ldc_channel_control_assertions u_chk (.clk(clk), .srst(srst), .measValid(measValid),
	.axiReq(axiReq), .axiRsp(axiRsp), .loopSel(loopSel), .freqSel(freqSel), .relayCoil(relayCoil),
	.chLed(chLed), .powerLed(powerLed), .irq(irq));

// file: ldc_loop_model.sv
`timescale 1ns/1ps
module ldc_loop_model #(
	parameter logic [23:0] BASE = 24'hF4240
) (
	input wire logic clk,
	input wire logic loopSel,
	input wire logic [23:0] delta0,
	input wire logic [23:0] delta1,
	output logic measValid,
	output logic [23:0] measCount
);
	// ====================
	// One gate count every fourth cycle
	logic [1:0] phase;
	initial begin
		phase = 2'h0;
		measValid = 1'b0;
		measCount = 24'h0;
	end
	// Outside a gate the count lines carry junk, never the last value
	always @(posedge clk) begin
		phase <= phase + 2'h1;
		measValid <= phase == 2'h3;
		measCount <= phase == 2'h3 ? BASE + (loopSel ? delta1 : delta0) : ~measCount;
	end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
	import ldc_pkg::*;
	localparam int TUNE = 200;
	logic clk, srst, btnN, mV, lSel, pwr, irq;
	logic [1:0] flt, relay, led, rr;
	logic [23:0] mCnt, d0, d1;
	logic [31:0] rd;
	int err_total, n_compared, i, n;
	// Count shift is half the inductance shift: 0.02, 0.05, 0.10, 0.50 percent of 1000000
	logic [23:0] thr [4] = '{24'h64, 24'hFA, 24'h1F4, 24'h9C4};
	ldc_sw_type sw;
	ldc_axi_req_type req;
	ldc_axi_rsp_type rsp;
	ldc_freq_type fsel;
	// Drift and the 4- and 40-minute holds keep their real lengths, far beyond the run
	ldc_channel_control #(.TUNE_CYC(40'hC8), .HOLD_1S_CYC(40'h32), .PARALYSIS_CYC(40'h64), .PULSE_CYC(24'h14),
		.DEBOUNCE_CYC(24'h8)) DUT (
		.clk(clk), .srst(srst), .swPins(sw), .resetButton_n(btnN), .measValid(mV), .measCount(mCnt),
		.loopFault(flt), .axiReq(req), .axiRsp(rsp), .loopSel(lSel), .freqSel(fsel), .relayCoil(relay),
		.chLed(led), .powerLed(pwr), .irq(irq));
	ldc_loop_model LM (.clk(clk), .loopSel(lSel), .delta0(d0), .delta1(d1), .measValid(mV), .measCount(mCnt));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ====================
	// Tasks
	task automatic wrap_up;
		if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic hang;
		err_total++;
		$display("[FAIL] wait limit exp 0 got 1");
		wrap_up();
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int k;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				req.bready <= 1'b0;
				break;
			end
		end
		if (k == 50) hang();
		@(posedge clk);
	endtask
	task automatic axr(input logic [7:0] a);
		int k;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
		if (k == 50) hang();
		@(posedge clk);
	endtask
	task automatic waitrel(input logic v, output int k);
		for (k = 0; k < 400 && relay[0] !== v; k++) @(posedge clk);
		if (k == 400) hang();
	endtask
	task automatic tune;
		cyc(20);
		axw(8'h00, 32'h1);
		cyc(TUNE + 12);
	endtask
	// ====================
	// Sequence
	initial begin
		srst = 1'b1;
		btnN = 1'b1;
		flt = 2'h0;
		d0 = 24'h0;
		d1 = 24'h0;
		sw = '0;
		req = '0;
		err_total = 0;
		n_compared = 0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		cyc(20);
		axr(8'h04);
		`CHK("boot tune", 1'b1, rd[0])
		`CHK("power", 1'b1, pwr)
		axr(8'h0C);
		`CHK("mask reset", 32'h0, rd)
		axr(8'h40);
		`CHK("unmapped", 2'h2, rr)
		cyc(TUNE);
		for (i = 0; i < 4; i++) begin
			d0 <= 24'h0;
			d1 <= 24'h0;
			sw <= ldc_sw_type'({2'b00, i[0], i[1], i[0], i[1], i[0], i[1], i[1], i[0]});
			tune();
			`CHK("freq", ldc_freq_type'(i), fsel)
			d0 <= thr[i] - 24'h1;
			cyc(12);
			`CHK("below thr", 1'b1, relay[0])
			d0 <= thr[i];
			cyc(12);
			`CHK("detect", 2'h2, relay)
			`CHK("led", 1'b1, led[0])
			d1 <= thr[i];
			cyc(12);
			`CHK("ch2 detect", 2'h0, relay)
		end
		sw <= '0;
		cyc(30);
		`CHK("cfg held", FREQ_LOW, fsel)
		d0 <= 24'h0;
		d1 <= 24'h0;
		sw <= ldc_sw_type'(10'h040);
		tune();
		d0 <= 24'h3E8;
		cyc(12);
		`CHK("4m detect", 1'b0, relay[0])
		d0 <= 24'h0;
		cyc(12);
		`CHK("leave", 1'b1, relay[0])
		d0 <= 24'h3E8;
		waitrel(1'b0, n);
		`CHK("paralysis", 1'b1, n > 80 && n < 115)
		cyc(290);
		`CHK("4m hold", 1'b0, relay[0])
		d0 <= 24'h0;
		cyc(20);
		`CHK("4m end", 1'b1, relay[0])
		d0 <= 24'h0;
		sw <= ldc_sw_type'(10'h0C0);
		tune();
		d0 <= 24'h3E8;
		waitrel(1'b0, n);
		cyc(45);
		`CHK("1s hold", 1'b0, relay[0])
		cyc(10);
		`CHK("1s end", 1'b1, relay[0])
		d0 <= 24'h44C;
		cyc(12);
		`CHK("1s again", 1'b0, relay[0])
		d0 <= 24'h0;
		sw <= ldc_sw_type'(10'h240);
		tune();
		`CHK("pulse idle", 1'b0, relay[0])
		d0 <= 24'h3E8;
		waitrel(1'b1, n);
		waitrel(1'b0, n);
		`CHK("pulse len", 20, n)
		cyc(30);
		`CHK("one pulse", 1'b0, relay[0])
		axw(8'h0C, 32'h8);
		flt <= 2'h2;
		cyc(4);
		`CHK("fault relay", 1'b0, relay[1])
		`CHK("irq on", 1'b1, irq)
		axr(8'h08);
		`CHK("fault flag", 1'b1, rd[3])
		axw(8'h0C, 32'h0);
		cyc(2);
		`CHK("irq masked", 1'b0, irq)
		axw(8'h0C, 32'h8);
		axw(8'h08, 32'h8);
		cyc(2);
		`CHK("irq clear", 1'b0, irq)
		flt <= 2'h0;
		d0 <= 24'h13880;
		cyc(12);
		axr(8'h04);
		`CHK("big retune", 1'b1, rd[0])
		cyc(TUNE + 12);
		for (i = 0; i < 3; i++) begin
			btnN <= 1'b0;
			cyc(3);
			btnN <= 1'b1;
			cyc(3);
		end
		cyc(20);
		axr(8'h04);
		`CHK("bounce", 1'b0, rd[0])
		btnN <= 1'b0;
		cyc(30);
		btnN <= 1'b1;
		axr(8'h04);
		`CHK("button", 1'b1, rd[0])
		wrap_up();
	end
endmodule
